// *** rtl/iodp_pkg.sv ***
package iodp_pkg;
   localparam logic [15:0] IODP_FIXED_BASE = 16'h0000;
   localparam logic [15:0] IODP_FIXED_LAST = 16'h3fff;
   localparam logic [15:0] IODP_PAGED_BASE = 16'h4000;
   localparam logic [15:0] IODP_PAGED_LAST = 16'h7fff;
   localparam logic [15:0] IODP_PAGE_WIN_BASE = 16'hbe80;
   localparam logic [15:0] IODP_SERIAL1_BASE = 16'hbe00;
   localparam logic [15:0] IODP_SERIAL2_BASE = 16'hbd80;
   localparam logic [15:0] IODP_PARALLEL_BASE = 16'hbf00;
   localparam logic [15:0] IODP_CALENDAR_BASE = 16'hbf80;
   localparam logic [15:0] IODP_ROM_BASE = 16'hc000;
   localparam logic [15:0] IODP_LAYOUT_ONE_RAM_LAST = 16'h7fff;
   localparam logic [15:0] IODP_LAYOUT_TWO_RAM_LAST = 16'h9fff;
   localparam int IODP_WIN_SHIFT = 7;
   localparam int IODP_PAGE_SHIFT = 14;
   localparam int IODP_PAGE_W = 5;
   localparam int IODP_RAM_ADDR_W = 19;
   localparam logic [4:0] IODP_PAGE_RESET = 5'h00;
   localparam int IODP_SERIAL_REG_W = 2;
   localparam int IODP_PARALLEL_REG_W = 4;
   localparam int IODP_CALENDAR_REG_W = 5;
endpackage

// *** rtl/iodp_window_match.sv ***
`timescale 1ns/1ps
module iodp_window_match #(
   parameter logic [15:0] BASE = 16'h0000,
   parameter int SHIFT = 7
) (
   input wire logic [15:0] addr,
   output logic hit
);
   // A whole window matches, so small devices echo throughout it.
   assign hit = (addr[15:SHIFT] == BASE[15:SHIFT]);
endmodule

// *** rtl/iodp_decoder.sv ***
`timescale 1ns/1ps
// Operation
// RQ1: A write anywhere in the page window loads the write-only 5-bit page latch.
// RQ2: The lowest 16 kbyte always reaches the same fixed RAM region.
// RQ3: The second 16 kbyte window reaches the page chosen by the latch.
// RQ4: Software keeps page values within the installed RAM size.
// RQ5: With paging present only layout one is decoded.
// RQ6: First serial chip at its base window, second one window below.
// RQ7: Serial chips use the two lowest address bits as register index.
// RQ8: A strap input selects which of two memory layouts is decoded.
// RQ9: Paged RAM addressing spans at most 512 kbyte.
// RQ10: Every peripheral is selected across a whole 128-byte window.
// RQ11: Parallel chip window uses the four lowest bits as register index.
// RQ12: Calendar chip window uses the five lowest bits as register index.
// RQ13: Paged physical address is (page plus one) times 16 kbyte plus offset.
// RQ14: The page latch clears to zero on reset.
module iodp_decoder #(
   parameter bit PAGING_PRESENT = 1'b1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] cpuAddr,
   input wire logic [7:0] cpuData,
   input wire logic cpuWrite,
   input wire logic cpuValid,
   input wire logic layoutSelectStrap,
   output logic [18:0] ramAddr,
   output logic ramSelect,
   output logic romSelect,
   output logic serial1Select,
   output logic serial2Select,
   output logic [1:0] serialRegIndex,
   output logic parallelSelect,
   output logic [3:0] parallelRegIndex,
   output logic calendarSelect,
   output logic [4:0] calendarRegIndex,
   output logic pageLatchSelect
);
   logic [4:0] ramPageSelect_reg;
   logic hitPage;
   logic hitSer1;
   logic hitSer2;
   logic hitPar;
   logic hitCal;
   logic layoutTwo;
   logic [15:0] ramLast;
   logic inFixed;
   logic inPaged;
   logic inRam;
   logic [18:0] ramAddr_next;
   logic [4:0] pagePlusOne;

   // The helper decodes all five 128-byte windows.
   iodp_window_match #(.BASE(iodp_pkg::IODP_PAGE_WIN_BASE), .SHIFT(iodp_pkg::IODP_WIN_SHIFT))
      uPage (.addr(cpuAddr), .hit(hitPage)); // RQ10
   iodp_window_match #(.BASE(iodp_pkg::IODP_SERIAL1_BASE), .SHIFT(iodp_pkg::IODP_WIN_SHIFT))
      uSer1 (.addr(cpuAddr), .hit(hitSer1)); // RQ6
   iodp_window_match #(.BASE(iodp_pkg::IODP_SERIAL2_BASE), .SHIFT(iodp_pkg::IODP_WIN_SHIFT))
      uSer2 (.addr(cpuAddr), .hit(hitSer2)); // RQ6
   iodp_window_match #(.BASE(iodp_pkg::IODP_PARALLEL_BASE), .SHIFT(iodp_pkg::IODP_WIN_SHIFT))
      uPar (.addr(cpuAddr), .hit(hitPar)); // RQ11
   iodp_window_match #(.BASE(iodp_pkg::IODP_CALENDAR_BASE), .SHIFT(iodp_pkg::IODP_WIN_SHIFT))
      uCal (.addr(cpuAddr), .hit(hitCal)); // RQ12

   // Paging forces layout one whatever the strap says.
   assign layoutTwo = layoutSelectStrap & ~PAGING_PRESENT; // RQ5 RQ8
   assign ramLast = layoutTwo ? iodp_pkg::IODP_LAYOUT_TWO_RAM_LAST
                              : iodp_pkg::IODP_LAYOUT_ONE_RAM_LAST; // RQ8
   assign inFixed = (cpuAddr <= iodp_pkg::IODP_FIXED_LAST); // RQ2
   assign inPaged = (cpuAddr >= iodp_pkg::IODP_PAGED_BASE) &&
                    (cpuAddr <= iodp_pkg::IODP_PAGED_LAST); // RQ3
   assign inRam = (cpuAddr <= ramLast);
   assign pagePlusOne = ramPageSelect_reg + 5'h01; // RQ13

   always_comb begin
      if (PAGING_PRESENT && inPaged) begin
         // Page 31 wraps onto the fixed region; software must avoid it.
         ramAddr_next = {pagePlusOne[4:0], cpuAddr[13:0]}; // RQ3 RQ9 RQ13
      end else if (inFixed) begin
         ramAddr_next = {5'h00, cpuAddr[13:0]}; // RQ2
      end else begin
         ramAddr_next = {3'h0, cpuAddr};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ramPageSelect_reg <= iodp_pkg::IODP_PAGE_RESET; // RQ14
      end else if (PAGING_PRESENT && cpuValid && cpuWrite && hitPage) begin
         ramPageSelect_reg <= cpuData[4:0]; // RQ1
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ramAddr <= 19'h00000;
         ramSelect <= 1'b0;
         romSelect <= 1'b0;
         serial1Select <= 1'b0;
         serial2Select <= 1'b0;
         serialRegIndex <= 2'h0;
         parallelSelect <= 1'b0;
         parallelRegIndex <= 4'h0;
         calendarSelect <= 1'b0;
         calendarRegIndex <= 5'h00;
         pageLatchSelect <= 1'b0;
      end else begin
         ramAddr <= ramAddr_next;
         ramSelect <= cpuValid && inRam; // RQ2 RQ3 RQ8
         romSelect <= cpuValid && (cpuAddr >= iodp_pkg::IODP_ROM_BASE);
         serial1Select <= cpuValid && hitSer1; // RQ6
         serial2Select <= cpuValid && hitSer2; // RQ6
         serialRegIndex <= cpuAddr[1:0]; // RQ7
         parallelSelect <= cpuValid && hitPar; // RQ11
         parallelRegIndex <= cpuAddr[3:0]; // RQ11
         calendarSelect <= cpuValid && hitCal; // RQ12
         calendarRegIndex <= cpuAddr[4:0]; // RQ12
         pageLatchSelect <= PAGING_PRESENT && cpuValid && cpuWrite && hitPage; // RQ1
      end
   end

   property p_latch_load;
      @(posedge clk) disable iff (!rstn)
      (PAGING_PRESENT && cpuValid && cpuWrite && hitPage) |=>
         ramPageSelect_reg == $past(cpuData[4:0]);
   endproperty
   a_latch_load: assert property (p_latch_load) else $error("Page latch not loaded."); // RQ1

   property p_latch_hold;
      @(posedge clk) disable iff (!rstn)
      !(cpuValid && cpuWrite && hitPage) |=> $stable(ramPageSelect_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("Page latch changed unasked."); // RQ1

   property p_fixed;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && inFixed) |=> ramSelect && ramAddr == {5'h00, $past(cpuAddr[13:0])};
   endproperty
   a_fixed: assert property (p_fixed) else $error("Fixed region misaddressed."); // RQ2

   property p_paged;
      @(posedge clk) disable iff (!rstn)
      (PAGING_PRESENT && cpuValid && inPaged) |=>
         ramSelect && ramAddr[18:14] == $past(ramPageSelect_reg) + 5'h01;
   endproperty
   a_paged: assert property (p_paged) else $error("Paged window misaddressed."); // RQ13

   property p_serial;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr[15:7] == 9'h17b) |=> serial2Select && !serial1Select;
   endproperty
   a_serial: assert property (p_serial) else $error("Second serial not selected."); // RQ6

   property p_serial_idx;
      @(posedge clk) disable iff (!rstn)
      serial1Select |-> serialRegIndex == $past(cpuAddr[1:0]);
   endproperty
   a_serial_idx: assert property (p_serial_idx) else $error("Serial index wrong."); // RQ7

   property p_layout;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr == 16'h9000) |=>
         ramSelect == (!PAGING_PRESENT && $past(layoutSelectStrap));
   endproperty
   a_layout: assert property (p_layout) else $error("Layout decode wrong."); // RQ8

   property p_onehot;
      @(posedge clk) disable iff (!rstn)
      $onehot0({serial1Select, serial2Select, parallelSelect, calendarSelect, pageLatchSelect});
   endproperty
   a_onehot: assert property (p_onehot) else $error("Peripheral windows overlap."); // RQ10

   property p_cal;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr[15:7] == 9'h17f) |=>
         calendarSelect && calendarRegIndex == $past(cpuAddr[4:0]);
   endproperty
   a_cal: assert property (p_cal) else $error("Calendar decode wrong."); // RQ12

   property p_serial1;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr[15:7] == 9'h17c) |=> serial1Select && !serial2Select;
   endproperty
   a_serial1: assert property (p_serial1) else $error("First serial not selected."); // RQ6

   property p_serial2_idx;
      @(posedge clk) disable iff (!rstn)
      serial2Select |-> serialRegIndex == $past(cpuAddr[1:0]);
   endproperty
   a_serial2_idx: assert property (p_serial2_idx) else $error("Serial two index wrong."); // RQ7

   property p_parallel;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr[15:7] == 9'h17e) |=>
         parallelSelect && parallelRegIndex == $past(cpuAddr[3:0]);
   endproperty
   a_parallel: assert property (p_parallel) else $error("Parallel decode wrong."); // RQ11

   property p_latch_read;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && !cpuWrite && hitPage) |=> !pageLatchSelect && $stable(ramPageSelect_reg);
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("Page latch read effect."); // RQ1

   property p_rom;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && cpuAddr >= iodp_pkg::IODP_ROM_BASE) |=> romSelect && !ramSelect;
   endproperty
   a_rom: assert property (p_rom) else $error("ROM region not selected."); // RQ8

   property p_page_win;
      @(posedge clk) disable iff (!rstn)
      (cpuValid && hitPage) |=> !ramSelect && !serial1Select && !serial2Select;
   endproperty
   a_page_win: assert property (p_page_win) else $error("Page window selects a device."); // RQ10

   property p_idle;
      @(posedge clk) disable iff (!rstn)
      !cpuValid |=> !ramSelect && !romSelect && !serial1Select && !serial2Select &&
         !parallelSelect && !calendarSelect && !pageLatchSelect;
   endproperty
   a_idle: assert property (p_idle) else $error("Select without a bus cycle."); // RQ10

   c_page_write: cover property (@(posedge clk) disable iff (!rstn) pageLatchSelect);
   c_paged_use: cover property (@(posedge clk) disable iff (!rstn)
      ramSelect && ramAddr[18:14] == 5'h1f);
   c_serial2: cover property (@(posedge clk) disable iff (!rstn) serial2Select);
   c_parallel: cover property (@(posedge clk) disable iff (!rstn) parallelSelect);
   c_rom: cover property (@(posedge clk) disable iff (!rstn) romSelect);
endmodule

// *** verification/iodp_cpu_model.sv ***
`timescale 1ns/1ps
module iodp_cpu_model (
   input wire logic clk,
   output logic [15:0] cpuAddr,
   output logic [7:0] cpuData,
   output logic cpuWrite,
   output logic cpuValid
);
   initial begin
      cpuAddr = 16'hffff;
      cpuData = 8'hff;
      cpuWrite = 1'b0;
      cpuValid = 1'b0;
   end
   // Holds one bus cycle for one edge, then leaves inverted address and data on the lines with write and valid low.
   task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w);
      @(posedge clk);
      cpuAddr <= a;
      cpuData <= d;
      cpuWrite <= w;
      cpuValid <= 1'b1;
      @(posedge clk);
      cpuAddr <= ~a;
      cpuData <= ~d;
      cpuWrite <= 1'b0;
      cpuValid <= 1'b0;
   endtask
endmodule

// *** verification/iodp_decoder_test.sv ***
`timescale 1ns/1ps
module iodp_decoder_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic layoutSelectStrap = 1'b0;
   logic [15:0] cpuAddr;
   logic [7:0] cpuData;
   logic cpuWrite, cpuValid, ramSelect, romSelect, serial1Select, serial2Select;
   logic parallelSelect, calendarSelect, pageLatchSelect;
   logic [18:0] ramAddr;
   logic [1:0] serialRegIndex;
   logic [3:0] parallelRegIndex;
   logic [4:0] calendarRegIndex;
   int failures = 0;
   int checks = 0;
   logic [4:0] pages [4] = '{5'h00, 5'h06, 5'h0e, 5'h1e};
   always #2 clk = ~clk;
   iodp_cpu_model cpu_u (.clk(clk), .cpuAddr(cpuAddr), .cpuData(cpuData),
      .cpuWrite(cpuWrite), .cpuValid(cpuValid));
   iodp_decoder dut_u (.clk(clk), .rstn(rstn), .cpuAddr(cpuAddr), .cpuData(cpuData),
      .cpuWrite(cpuWrite), .cpuValid(cpuValid), .layoutSelectStrap(layoutSelectStrap),
      .ramAddr(ramAddr), .ramSelect(ramSelect), .romSelect(romSelect),
      .serial1Select(serial1Select), .serial2Select(serial2Select),
      .serialRegIndex(serialRegIndex), .parallelSelect(parallelSelect),
      .parallelRegIndex(parallelRegIndex), .calendarSelect(calendarSelect),
      .calendarRegIndex(calendarRegIndex), .pageLatchSelect(pageLatchSelect));
   task automatic chk(input string name, input logic [18:0] exp, input logic [18:0] got);
      checks++;
      if (exp !== got) begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
      cpu_u.access(a, d, w);
      #1;
   endtask
   task automatic final_report();
      if (failures == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      acc(16'h4000, 8'h00, 1'b0);
      chk("ramAddr", 19'h04000, ramAddr);
      foreach (pages[i]) begin
         acc({9'h17d, 7'(i * 42)}, {3'h7, pages[i]}, 1'b1);
         chk("pageLatchSelect", 19'h1, 19'(pageLatchSelect));
         acc(16'h7ffc + 16'(i), 8'h00, 1'b0);
         chk("ramAddr", {pages[i] + 5'h01, 14'h3ffc + 14'(i)}, ramAddr);
         chk("ramSelect", 19'h1, 19'(ramSelect));
         acc(16'h3fff, 8'h00, 1'b1);
         chk("ramAddr", 19'h03fff, ramAddr);
         chk("ramSelect", 19'h1, 19'(ramSelect));
      end
      acc(16'hbec0, 8'h05, 1'b0);
      chk("pageLatchSelect", 19'h0, 19'(pageLatchSelect));
      acc(16'h4000, 8'h00, 1'b0);
      chk("ramAddr", 19'h7c000, ramAddr);
      for (int k = 0; k < 4; k++) begin
         acc(16'hbe00 + 16'(k * 33), 8'h00, 1'b0);
         chk("serial1Select", 19'h1, 19'(serial1Select));
         chk("serialRegIndex", 19'(k), 19'(serialRegIndex));
         acc(16'hbd80 + 16'(k * 33), 8'h00, 1'b1);
         chk("serial2Select", 19'h1, 19'(serial2Select));
         chk("serialRegIndex", 19'(k), 19'(serialRegIndex));
      end
      acc(16'hbf7b, 8'h00, 1'b0);
      chk("parallelRegIndex", 19'hb, 19'(parallelRegIndex));
      chk("parallelSelect", 19'h1, 19'(parallelSelect));
      acc(16'hbfff, 8'h00, 1'b0);
      chk("calendarRegIndex", 19'h1f, 19'(calendarRegIndex));
      chk("calendarSelect", 19'h1, 19'(calendarSelect));
      @(posedge clk);
      layoutSelectStrap <= 1'b1;
      acc(16'h8000, 8'h00, 1'b0);
      chk("ramSelect", 19'h0, 19'(ramSelect));
      acc(16'h9000, 8'h00, 1'b0);
      chk("ramSelect", 19'h0, 19'(ramSelect));
      acc(16'hc000, 8'h00, 1'b0);
      chk("romSelect", 19'h1, 19'(romSelect));
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("ramAddr", 19'h00000, ramAddr);
      @(posedge clk);
      rstn <= 1'b1;
      acc(16'h4000, 8'h00, 1'b0);
      chk("ramAddr", 19'h04000, ramAddr);
      final_report();
   end
endmodule
